/* inc/clock_source_pkg.sv */
package clock_source_pkg;
  // register indices on the 2-bit address port
  localparam logic [1:0] ADDR_CLOCK_SELECT = 2'h0;
  localparam logic [1:0] ADDR_OSC_DIVIDER = 2'h1;
  localparam logic [1:0] ADDR_REF_TRIM = 2'h2;
  localparam logic [1:0] ADDR_STATUS_TRIM = 2'h3;

  // reset values
  localparam logic [7:0] CLOCK_SELECT_RESET = 8'h04;
  localparam logic [7:0] OSC_DIVIDER_RESET = 8'h40;
  localparam logic [7:0] REF_TRIM_RESET = 8'h80;
  localparam logic FINE_TRIM_RESET = 1'b0;

  // clock_select_control fields
  localparam int SRC_SEL_LSB = 6;
  localparam int REF_DIV_LSB = 3;
  localparam int LOOP_REF_SEL_BIT = 2;
  localparam int INT_OUT_EN_BIT = 1;
  localparam int INT_STOP_EN_BIT = 0;

  // oscillator_divider_control fields
  localparam int BUS_DIV_LSB = 6;
  localparam int OSC_RANGE_BIT = 5;
  localparam int OSC_GAIN_BIT = 4;
  localparam int LOW_POWER_BIT = 3;
  localparam int EXT_KIND_BIT = 2;
  localparam int EXT_OUT_EN_BIT = 1;
  localparam int EXT_STOP_EN_BIT = 0;

  // mode_status_fine_trim fields
  localparam int STATUS_SRC_LSB = 2;
  localparam int OSC_READY_BIT = 1;
  localparam int FINE_TRIM_BIT = 0;

  // source select codes
  localparam logic [1:0] SRC_LOOP = 2'h0;
  localparam logic [1:0] SRC_INTERNAL = 2'h1;
  localparam logic [1:0] SRC_EXTERNAL = 2'h2;
  localparam logic [1:0] SRC_RESERVED = 2'h3;

  typedef enum logic [6:0] {
    MODE_ENGAGED_INT = 7'h01,
    MODE_ENGAGED_EXT = 7'h02,
    MODE_BYPASS_INT = 7'h04,
    MODE_BYPASS_INT_LP = 7'h08,
    MODE_BYPASS_EXT = 7'h10,
    MODE_BYPASS_EXT_LP = 7'h20,
    MODE_STOP = 7'h40
  } clock_mode_t;
endpackage

/* verilog/pin_edge_sync.sv */
`timescale 1ns/1ps
module pin_edge_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // asynchronous pin
  input wire logic pin,
  // synchronised level and rising-edge pulse
  output logic level,
  output logic rise
);
  logic meta;
  logic last;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 1'b0;
      level <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin;
      level <= meta;
      last <= level;
    end
  end

  assign rise = level & ~last;
endmodule // pin_edge_sync

/* verilog/clock_source_unit.sv */
`timescale 1ns/1ps
// Summary of operation
// [RQ1] system clock out passes a bus divider; bus clock runs at half its rate
// [RQ2] two-bit bus divider select gives divide by 1, 2, 4 or 8
// [RQ3] reset leaves the unit in engaged-internal mode
// [RQ4] reference divider field bits 5:3 divides loop reference by two to that power
// [RQ5] software keeps the divided loop reference inside its allowed band
// [RQ6] source select bits 7:6 pick loop, internal or external; code 11 acts as 00
// [RQ7] bit 2 picks loop reference: 0 external, 1 internal
// [RQ8] bit 1 gates the internal reference clock output
// [RQ9] internal reference survives stop only with stop enable and prior use or enable
// [RQ10] engaged-internal: loop output drives clock, loop follows internal reference
// [RQ11] engaged-external: loop output drives clock, loop follows external reference
// [RQ12] bypassed-internal: loop on with internal reference, clock from internal reference; code takes the loop reference from bit 2 here
// [RQ13] bypassed-internal low power: loop off, clock from internal reference
// [RQ14] bypassed-external: loop on with external reference, clock from external reference; code takes the loop reference from bit 2 here
// [RQ15] bypassed-external low power: loop off, clock from external reference
// [RQ16] stop: loop off, no system clock, references follow their enables
// [RQ17] software keeps any loop reference at or below its maximum frequency
// [RQ18] oscillator controls driven: range, gain, kind, enable, stop enable
// [RQ19] internal reference trimmed by eight coarse bits plus one fine bit
// [RQ20] low-power bit 3 of second register disables loop while bypassed
// [RQ21] bus divider codes 00..11 divide 1,2,4,8; reset gives divide by 2
// [RQ22] mode status shows the active source only after synchronisation
// [RQ23] oscillator ready sets after start-up when requested with crystal, clears on disable
// [RQ24] source code 01 internal reference, 10 external reference
// [RQ25] source switching waits for an edge of the new source
module clock_source_unit
  import clock_source_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  // clock source pins
  input wire logic fll_clk_in,
  input wire logic int_ref_clk_in,
  input wire logic ext_ref_clk_in,
  input wire logic stop_req,
  input wire logic osc_init_done,
  // clock enables out
  output logic system_clock_out,
  output logic bus_clock_out,
  output logic internal_ref_clock_out,
  output logic external_ref_clock_out,
  output logic loop_ref_tick,
  // analog control
  output logic loop_enable,
  output logic internal_ref_run,
  output logic external_ref_run,
  output logic [8:0] ref_trim,
  // oscillator control
  output logic osc_range,
  output logic osc_high_gain_select,
  output logic external_ref_kind_select,
  output logic osc_enable,
  output logic osc_stop_enable
);
  logic [7:0] clock_select_control;
  logic [7:0] oscillator_divider_control;
  logic [7:0] reference_trim;
  logic fine_trim_bit;
  logic oscillator_ready;
  logic [1:0] active_source_status;
  clock_mode_t mode;
  clock_mode_t next_mode;
  logic prior_int;
  logic prior_ext;
  logic [6:0] ref_cnt;
  logic [2:0] bus_cnt;
  logic bus_phase;

  logic fll_rise;
  logic int_rise;
  logic ext_rise;
  logic stop_level;
  logic osc_done_level;

  // field views
  logic [1:0] source_select;
  logic [2:0] reference_divider_select;
  logic loop_reference_select;
  logic internal_ref_out_enable;
  logic internal_ref_stop_enable;
  logic [1:0] bus_divider_select;
  logic bypass_low_power_select;
  logic external_ref_out_enable;
  logic external_ref_stop_enable;
  logic [1:0] req_src;
  logic loop_ref_rise;
  logic src_rise;
  logic new_src_rise;
  logic int_needed;
  logic ext_needed;

  function automatic logic [6:0] div_last(input logic [2:0] code);
    div_last = 7'((8'h01 << code) - 8'h01);
  endfunction

  function automatic logic src_edge(input logic [1:0] src, input logic f, input logic i,
                                    input logic e);
    case (src)
      SRC_INTERNAL: src_edge = i;
      SRC_EXTERNAL: src_edge = e;
      default: src_edge = f;
    endcase
  endfunction

  pin_edge_sync u_fll_sync (.sys_clk(sys_clk), .rst_b(rst_b), .pin(fll_clk_in),
    .level(), .rise(fll_rise));
  pin_edge_sync u_int_sync (.sys_clk(sys_clk), .rst_b(rst_b), .pin(int_ref_clk_in),
    .level(), .rise(int_rise));
  pin_edge_sync u_ext_sync (.sys_clk(sys_clk), .rst_b(rst_b), .pin(ext_ref_clk_in),
    .level(), .rise(ext_rise));
  pin_edge_sync u_stop_sync (.sys_clk(sys_clk), .rst_b(rst_b), .pin(stop_req),
    .level(stop_level), .rise());
  pin_edge_sync u_osc_sync (.sys_clk(sys_clk), .rst_b(rst_b), .pin(osc_init_done),
    .level(osc_done_level), .rise());

  assign source_select = clock_select_control[SRC_SEL_LSB +: 2];
  assign reference_divider_select = clock_select_control[REF_DIV_LSB +: 3];
  assign loop_reference_select = clock_select_control[LOOP_REF_SEL_BIT];
  assign internal_ref_out_enable = clock_select_control[INT_OUT_EN_BIT];
  assign internal_ref_stop_enable = clock_select_control[INT_STOP_EN_BIT];
  assign bus_divider_select = oscillator_divider_control[BUS_DIV_LSB +: 2];
  assign bypass_low_power_select = oscillator_divider_control[LOW_POWER_BIT];
  assign external_ref_out_enable = oscillator_divider_control[EXT_OUT_EN_BIT];
  assign external_ref_stop_enable = oscillator_divider_control[EXT_STOP_EN_BIT];

  assign req_src = (source_select == SRC_RESERVED) ? SRC_LOOP : source_select; // see [RQ6] [RQ24]
  assign loop_ref_rise = loop_reference_select ? int_rise : ext_rise; // see [RQ7]
  assign src_rise = src_edge(active_source_status, fll_rise, int_rise, ext_rise);
  assign new_src_rise = src_edge(req_src, fll_rise, int_rise, ext_rise);

  // register writes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clock_select_control <= CLOCK_SELECT_RESET; // see [RQ3] [RQ4]
      oscillator_divider_control <= OSC_DIVIDER_RESET; // see [RQ21]
      reference_trim <= REF_TRIM_RESET;
      fine_trim_bit <= FINE_TRIM_RESET;
    end else if (wr_en) begin
      case (addr)
        ADDR_CLOCK_SELECT: clock_select_control <= wr_data;
        ADDR_OSC_DIVIDER: oscillator_divider_control <= wr_data;
        ADDR_REF_TRIM: reference_trim <= wr_data; // see [RQ19]
        default: fine_trim_bit <= wr_data[FINE_TRIM_BIT]; // see [RQ19]
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        ADDR_CLOCK_SELECT: rd_data <= clock_select_control;
        ADDR_OSC_DIVIDER: rd_data <= oscillator_divider_control;
        ADDR_REF_TRIM: rd_data <= reference_trim;
        default: rd_data <= {4'h0, active_source_status, oscillator_ready, fine_trim_bit};
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end

  // mode decode from requested source, reference select and low-power bit
  always_comb begin
    next_mode = MODE_ENGAGED_INT;
    if (stop_level) begin
      next_mode = MODE_STOP; // see [RQ16]
    end else begin
      case (req_src)
        SRC_INTERNAL: next_mode = bypass_low_power_select ? MODE_BYPASS_INT_LP
                                                          : MODE_BYPASS_INT; // see [RQ12] [RQ13] [RQ20]
        SRC_EXTERNAL: next_mode = bypass_low_power_select ? MODE_BYPASS_EXT_LP
                                                          : MODE_BYPASS_EXT; // see [RQ14] [RQ15] [RQ20]
        default: next_mode = loop_reference_select ? MODE_ENGAGED_INT
                                                   : MODE_ENGAGED_EXT; // see [RQ10] [RQ11]
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= MODE_ENGAGED_INT; // see [RQ3]
    end else begin
      mode <= next_mode;
    end
  end

  // remember which reference the last running mode used, for stop entry
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prior_int <= 1'b1;
      prior_ext <= 1'b0;
    end else if (mode != MODE_STOP) begin
      prior_int <= (mode == MODE_ENGAGED_INT) || (mode == MODE_BYPASS_INT) ||
                   (mode == MODE_BYPASS_INT_LP);
      prior_ext <= (mode == MODE_ENGAGED_EXT) || (mode == MODE_BYPASS_EXT) ||
                   (mode == MODE_BYPASS_EXT_LP);
    end
  end

  // handover only on an edge of the new source so no runt pulse reaches the tree
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      active_source_status <= SRC_LOOP;
    end else if (active_source_status != req_src && new_src_rise) begin
      active_source_status <= req_src; // see [RQ25] [RQ22]
    end
  end

  // loop on in engaged modes and non-low-power bypass modes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      loop_enable <= 1'b1;
    end else begin
      loop_enable <= (next_mode == MODE_ENGAGED_INT) || (next_mode == MODE_ENGAGED_EXT) ||
                     (next_mode == MODE_BYPASS_INT) || (next_mode == MODE_BYPASS_EXT); // see [RQ20]
    end
  end

  // reference oscillator run enables
  assign int_needed = (mode == MODE_STOP)
    ? (internal_ref_stop_enable && (internal_ref_out_enable || prior_int)) // see [RQ9]
    : (internal_ref_out_enable || loop_reference_select || req_src == SRC_INTERNAL);
  assign ext_needed = (mode == MODE_STOP)
    ? (external_ref_stop_enable && (external_ref_out_enable || prior_ext))
    : (external_ref_out_enable || !loop_reference_select || req_src == SRC_EXTERNAL);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      internal_ref_run <= 1'b1;
      external_ref_run <= 1'b0;
      internal_ref_clock_out <= 1'b0;
      external_ref_clock_out <= 1'b0;
    end else begin
      internal_ref_run <= int_needed; // see [RQ16]
      external_ref_run <= ext_needed; // see [RQ16]
      internal_ref_clock_out <= int_rise && internal_ref_out_enable && int_needed; // see [RQ8]
      external_ref_clock_out <= ext_rise && external_ref_out_enable && ext_needed;
    end
  end

  // loop reference divider: one tick per 2^code reference edges
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_cnt <= 7'h00;
      loop_ref_tick <= 1'b0;
    end else begin
      loop_ref_tick <= 1'b0;
      if (loop_ref_rise && loop_enable) begin
        if (ref_cnt >= div_last(reference_divider_select)) begin
          ref_cnt <= 7'h00;
          loop_ref_tick <= 1'b1; // see [RQ4]
        end else begin
          ref_cnt <= ref_cnt + 7'h01;
        end
      end
    end
  end

  // bus divider, then system clock and half-rate bus clock
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_cnt <= 3'h0;
      bus_phase <= 1'b0;
      system_clock_out <= 1'b0;
      bus_clock_out <= 1'b0;
    end else begin
      system_clock_out <= 1'b0;
      bus_clock_out <= 1'b0;
      if (src_rise && mode != MODE_STOP) begin
        if (bus_cnt >= 3'(div_last({1'b0, bus_divider_select}))) begin
          bus_cnt <= 3'h0;
          system_clock_out <= 1'b1; // see [RQ2] [RQ21]
          bus_phase <= ~bus_phase;
          bus_clock_out <= bus_phase; // see [RQ1]
        end else begin
          bus_cnt <= bus_cnt + 3'h1;
        end
      end
    end
  end

  // oscillator start-up flag; set wins over clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      oscillator_ready <= 1'b0;
    end else if (osc_done_level && oscillator_divider_control[EXT_KIND_BIT] &&
                 (external_ref_out_enable || prior_ext)) begin
      oscillator_ready <= 1'b1; // see [RQ23]
    end else if (!oscillator_divider_control[EXT_KIND_BIT] ||
                 !(external_ref_out_enable || prior_ext)) begin
      oscillator_ready <= 1'b0; // see [RQ23]
    end
  end

  // oscillator and trim outputs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_range <= 1'b0;
      osc_high_gain_select <= 1'b0;
      external_ref_kind_select <= 1'b0;
      osc_enable <= 1'b0;
      osc_stop_enable <= 1'b0;
      ref_trim <= {REF_TRIM_RESET, FINE_TRIM_RESET};
    end else begin
      osc_range <= oscillator_divider_control[OSC_RANGE_BIT]; // see [RQ18]
      osc_high_gain_select <= oscillator_divider_control[OSC_GAIN_BIT];
      external_ref_kind_select <= oscillator_divider_control[EXT_KIND_BIT];
      osc_enable <= ext_needed;
      osc_stop_enable <= external_ref_stop_enable;
      ref_trim <= {reference_trim, fine_trim_bit}; // see [RQ19]
    end
  end

  // checking
  logic settled;
  logic [1:0] sys_since_bus;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      settled <= 1'b0;
      sys_since_bus <= 2'h0;
    end else begin
      settled <= 1'b1;
      if (bus_clock_out) begin
        sys_since_bus <= 2'h0;
      end else if (system_clock_out) begin
        sys_since_bus <= sys_since_bus + 2'h1;
      end
    end
  end

  sequence seq_switch_pending;
    active_source_status != req_src && !new_src_rise;
  endsequence

  sequence seq_switch_edge;
    active_source_status != req_src && new_src_rise;
  endsequence

  a_reset_mode: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ3]
    !settled |-> mode == MODE_ENGAGED_INT && active_source_status == SRC_LOOP && loop_enable)
    else $error("unit did not start in engaged-internal mode");

  a_bus_half_rate: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ1]
    bus_clock_out |-> system_clock_out && sys_since_bus == 2'h1)
    else $error("bus clock is not half the system clock");

  a_reserved_code: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ6]
    source_select == SRC_RESERVED |-> req_src == SRC_LOOP)
    else $error("reserved source code not treated as loop");

  a_switch_holds: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ25]
    seq_switch_pending |=> $stable(active_source_status))
    else $error("source switched without an edge of the new source");

  a_switch_takes: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ22]
    seq_switch_edge |=> active_source_status == $past(req_src))
    else $error("status did not follow the new source");

  a_stop_no_clock: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ16]
    mode == MODE_STOP |=> !system_clock_out && !bus_clock_out)
    else $error("system clock delivered in stop");

  a_low_power_loop: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ20]
    (req_src != SRC_LOOP && bypass_low_power_select) || stop_level |=> !loop_enable)
    else $error("loop enabled in a low-power or stop mode");

  a_int_out_gate: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ8]
    internal_ref_clock_out |-> $past(internal_ref_out_enable) && $past(int_rise))
    else $error("internal reference output active while disabled");

  a_int_stop_run: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ9]
    mode == MODE_STOP && !internal_ref_stop_enable |=> !internal_ref_run)
    else $error("internal reference kept running in stop without stop enable");

  a_osc_clear: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ23]
    !oscillator_divider_control[EXT_KIND_BIT] |=> !oscillator_ready)
    else $error("oscillator ready set with external clock kind");

  a_ref_divide: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ4]
    reference_divider_select == 3'h0 && loop_ref_rise && loop_enable |=> loop_ref_tick)
    else $error("divide-by-one reference missed a tick");
endmodule // clock_source_unit

/* tb/clock_sources.sv */
`timescale 1ns/1ps
module clock_sources (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // controls from the unit
  input wire logic loop_enable,
  input wire logic internal_ref_run,
  input wire logic osc_enable,
  input wire logic external_ref_kind_select,
  // source clocks and oscillator status
  output logic fll_clk_in,
  output logic int_ref_clk_in,
  output logic ext_ref_clk_in,
  output logic osc_init_done
);
  int start_cnt;
  initial begin
    fll_clk_in = 1'b0;
    int_ref_clk_in = 1'b0;
    ext_ref_clk_in = 1'b0;
  end
  // a stopped source holds low; periods are whole multiples of the sys_clk period
  always #100 fll_clk_in = loop_enable ? ~fll_clk_in : 1'b0;
  always #300 int_ref_clk_in = internal_ref_run ? ~int_ref_clk_in : 1'b0;
  // 2 MHz; a plain clock source runs without the oscillator enable
  always #250 ext_ref_clk_in = (osc_enable || !external_ref_kind_select) ? ~ext_ref_clk_in : 1'b0;
  // crystal start-up takes 32 cycles, lost again when disabled
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) start_cnt <= 0;
    else if (!(osc_enable && external_ref_kind_select)) start_cnt <= 0;
    else if (start_cnt < 32) start_cnt <= start_cnt + 1;
  end
  assign osc_init_done = (start_cnt == 32);
endmodule // clock_sources

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import clock_source_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, rd_en = 1'b0, stop_req = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wr_data = 8'h00, rd_data, d;
  logic fll_clk_in, int_ref_clk_in, ext_ref_clk_in, osc_init_done;
  logic system_clock_out, bus_clock_out, internal_ref_clock_out, external_ref_clock_out;
  logic loop_ref_tick, loop_enable, internal_ref_run, external_ref_run, osc_range;
  logic osc_high_gain_select, external_ref_kind_select, osc_enable, osc_stop_enable;
  logic [8:0] ref_trim;
  logic [2:0] src_d;
  logic counting = 1'b0;
  int mismatches = 0, total_checks = 0, cyc = 0;
  int n_sys, n_bus, n_fe, n_ie, n_ee, n_tick, n_io, n_eo;
  logic [31:0] seed = 32'h54FCF6A8;
  logic [7:0] v1, v2, v3;
  int dv;

  always #12.5 sys_clk = ~sys_clk;

  clock_source_unit dut (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .fll_clk_in(fll_clk_in),
    .int_ref_clk_in(int_ref_clk_in), .ext_ref_clk_in(ext_ref_clk_in), .stop_req(stop_req),
    .osc_init_done(osc_init_done), .system_clock_out(system_clock_out),
    .bus_clock_out(bus_clock_out), .internal_ref_clock_out(internal_ref_clock_out),
    .external_ref_clock_out(external_ref_clock_out), .loop_ref_tick(loop_ref_tick),
    .loop_enable(loop_enable), .internal_ref_run(internal_ref_run),
    .external_ref_run(external_ref_run), .ref_trim(ref_trim), .osc_range(osc_range),
    .osc_high_gain_select(osc_high_gain_select),
    .external_ref_kind_select(external_ref_kind_select), .osc_enable(osc_enable),
    .osc_stop_enable(osc_stop_enable));

  clock_sources far_side (.sys_clk(sys_clk), .rst_b(rst_b), .loop_enable(loop_enable),
    .internal_ref_run(internal_ref_run), .osc_enable(osc_enable),
    .external_ref_kind_select(external_ref_kind_select), .fll_clk_in(fll_clk_in),
    .int_ref_clk_in(int_ref_clk_in), .ext_ref_clk_in(ext_ref_clk_in),
    .osc_init_done(osc_init_done));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // pulses p of a source with e edges divided by dv; sync lag and phase allow slack
  function automatic bit near(input int p, input int e, input int dv);
    return (e > dv) && (p * dv - e <= 2 * dv) && (e - p * dv <= 2 * dv);
  endfunction

  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    src_d <= {fll_clk_in, int_ref_clk_in, ext_ref_clk_in};
    if (counting) begin
      n_sys += system_clock_out;
      n_bus += bus_clock_out;
      n_tick += loop_ref_tick;
      n_io += internal_ref_clock_out;
      n_eo += external_ref_clock_out;
      n_fe += fll_clk_in & ~src_d[2];
      n_ie += int_ref_clk_in & ~src_d[1];
      n_ee += ext_ref_clk_in & ~src_d[0];
    end
  end

  task automatic measure(input int n);
    @(posedge sys_clk);
    #1 {n_sys, n_bus, n_fe, n_ie, n_ee, n_tick, n_io, n_eo} = '0;
    counting = 1'b1;
    settle(n);
    #1 counting = 1'b0;
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      $display("ERROR %0t run did not finish", $time);
      end_of_test;
    end
  end

  initial begin
    settle(12);
    chk(loop_enable === 1'b1 && internal_ref_run === 1'b1, "reset mode");
    chk(ref_trim === 9'h100 && external_ref_run === 1'b0, "reset trim");
    @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(ADDR_CLOCK_SELECT, d);
    chk(d === 8'h04, "reset clock select");
    rd(ADDR_OSC_DIVIDER, d);
    chk(d === 8'h40, "reset divider");
    rd(ADDR_REF_TRIM, d);
    chk(d === 8'h80, "reset trim reg");
    rd(ADDR_STATUS_TRIM, d);
    chk(d === 8'h00, "reset status");
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_OSC_DIVIDER, {b[1:0], 6'h00});
      settle(16);
      measure(400);
      chk(near(n_sys, n_fe, 1 << b), "bus divider ratio");
      chk(n_sys - 2 * n_bus <= 2 && 2 * n_bus - n_sys <= 2, "bus half rate");
    end
    wr(ADDR_OSC_DIVIDER, 8'h02);
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk);
      addr <= ADDR_CLOCK_SELECT;
      wr_data <= {s[1:0], 6'h06};
      wr_en <= 1'b1;
      // read straight after the write: status cannot have moved yet
      @(posedge sys_clk);
      wr_en <= 1'b0;
      addr <= ADDR_STATUS_TRIM;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
      chk(d[3:2] === (s == 0 ? 2'h0 : 2'(s - 1)), "status lags");
      settle(40);
      rd(ADDR_STATUS_TRIM, d);
      chk(d[3:2] === (s == 3 ? 2'h0 : 2'(s)), "status source");
      measure(400);
      dv = (s == 1) ? n_ie : (s == 2) ? n_ee : n_fe;
      chk(near(n_sys, dv, 1) && loop_enable === 1'b1, "source rate");
    end
    for (int s = 0; s < 3; s++) begin
      wr(ADDR_OSC_DIVIDER, 8'h0A);
      wr(ADDR_CLOCK_SELECT, {s[1:0], 6'h06});
      settle(40);
      chk(loop_enable === (s == 0), "low power loop");
      measure(400);
      dv = (s == 1) ? n_ie : (s == 2) ? n_ee : n_fe;
      chk(near(n_sys, dv, 1), "bypass source rate");
    end
    wr(ADDR_OSC_DIVIDER, 8'h02);
    for (int r = 0; r < 6; r++) begin
      wr(ADDR_CLOCK_SELECT, {2'h0, 3'(r / 2), r[0], 2'h2});
      settle(40);
      measure(1200);
      chk(near(n_tick, r[0] ? n_ie : n_ee, 1 << (r / 2)), "reference divide");
    end
    for (int en = 0; en < 2; en++) begin
      wr(ADDR_CLOCK_SELECT, {5'h00, 1'b1, en[0], 1'b0});
      wr(ADDR_OSC_DIVIDER, {6'h00, en[0], 1'b0});
      settle(20);
      measure(800);
      chk(en ? near(n_io, n_ie, 1) : n_io == 0, "internal out gate");
      chk(en ? near(n_eo, n_ee, 1) : n_eo == 0, "external out gate");
    end
    // stop cases: {clock select, expected internal run}
    for (int i = 0; i < 4; i++) begin
      v2 = (i == 0) ? 8'h45 : (i == 1) ? 8'h81 : (i == 2) ? 8'h83 : 8'h46;
      wr(ADDR_OSC_DIVIDER, 8'h02);
      wr(ADDR_CLOCK_SELECT, v2);
      settle(20);
      @(posedge sys_clk);
      stop_req <= 1'b1;
      settle(10);
      chk(internal_ref_run === (i == 0 || i == 2), "stop internal run");
      chk(loop_enable === 1'b0, "stop loop off");
      measure(200);
      chk(n_sys == 0, "stop no clock");
      @(posedge sys_clk);
      stop_req <= 1'b0;
      settle(20);
    end
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      {v1, v2, v3} = seed[23:0];
      v1[7:6] = 2'h1;
      wr(ADDR_OSC_DIVIDER, v1);
      wr(ADDR_REF_TRIM, v2);
      wr(ADDR_STATUS_TRIM, v3);
      wr(ADDR_CLOCK_SELECT, seed[31:24]);
      settle(4);
      chk({osc_range, osc_high_gain_select} === v1[5:4], "osc range gain");
      chk({external_ref_kind_select, osc_stop_enable} === {v1[2], v1[0]}, "osc kind");
      chk(ref_trim === {v2, v3[0]}, "trim out");
      rd(ADDR_CLOCK_SELECT, d);
      chk(d === seed[31:24], "select readback");
      rd(ADDR_OSC_DIVIDER, d);
      chk(d === v1, "divider readback");
      rd(ADDR_REF_TRIM, d);
      chk(d === v2, "trim readback");
      rd(ADDR_STATUS_TRIM, d);
      chk(d[7:4] === 4'h0 && d[0] === v3[0], "fine trim readback");
    end
    wr(ADDR_CLOCK_SELECT, 8'h04);
    wr(ADDR_OSC_DIVIDER, 8'h06);
    settle(80);
    rd(ADDR_STATUS_TRIM, d);
    chk(d[1] === 1'b1 && osc_enable === 1'b1, "osc ready set");
    wr(ADDR_OSC_DIVIDER, 8'h02);
    settle(4);
    rd(ADDR_STATUS_TRIM, d);
    chk(d[1] === 1'b0, "osc ready clear");
    end_of_test;
  end
endmodule // tb
